// ===== logic/fsp_cfg.svh
// Opcodes, field positions, reset values and lock mode codes of the status block.
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH
`define FSP_OP_WREN      8'h06
`define FSP_OP_WRDI      8'h04
`define FSP_OP_VWREN     8'h50
`define FSP_OP_WRSR1     8'h01
`define FSP_OP_WRSR2     8'h31
`define FSP_OP_WRSR3     8'h11
`define FSP_OP_RDSR1     8'h05
`define FSP_OP_RDSR2     8'h35
`define FSP_OP_RDSR3     8'h15
`define FSP_OP_PROG      8'h02
`define FSP_OP_SECT_ER   8'h20
`define FSP_OP_BLK_ER    8'hD8
`define FSP_OP_CHIP_ER   8'hC7
`define FSP_OP_SUSPEND   8'h75
`define FSP_OP_RESUME    8'h7A
`define FSP_OP_SOFT_RST  8'h99
`define FSP_SR1_BUSY     0
`define FSP_SR1_WEL      1
`define FSP_SR1_BP_LSB   2
`define FSP_SR1_TB       5
`define FSP_SR1_SEC      6
`define FSP_SR1_LOCK_MODE_BIT0     7
`define FSP_SR2_LOCK_MODE_BIT1     0
`define FSP_SR2_QE       1
`define FSP_SR2_LB_LSB   3
`define FSP_SR2_CMP      6
`define FSP_SR2_SUS      7
`define FSP_SR3_WPS      2
`define FSP_SR3_HFM      4
`define FSP_SR3_DRV_LSB  5
`define FSP_SR3_PIN_ROLE_SELECT     7
`define FSP_DEF_BP       3'h0
`define FSP_DEF_DRV      2'h0
`define FSP_DEF_HFM      1'h1
`define FSP_DEF_LB       3'h0
`define FSP_LOCK_SOFT    2'h0
`define FSP_LOCK_HW      2'h1
`define FSP_LOCK_POWER   2'h2
`define FSP_LOCK_OTP     2'h3
`endif

// ===== logic/fsp_pkg.sv
// Types shared by the status and protection register block.
package fsp_pkg;
   // Configurable bits held in both a volatile and a persistent copy.
   typedef struct packed {
      logic       pin_role_select;
      logic [1:0] drive_strength;
      logic       high_freq_mode;
      logic       protect_scheme_select;
      logic       complement_protect;
      logic       quad_enable;
      logic       lock_mode_bit1;
      logic       lock_mode_bit0;
      logic       protect_unit_small;
      logic       top_bottom_select;
      logic [2:0] protect_level;
   } fsp_cfg_t;
   // One decoded instruction from the sequencer; data byte 0 first.
   typedef struct packed {
      logic [7:0]  code;
      logic [1:0]  nbytes;
      logic [15:0] data;
   } fsp_cmd_t;
   // Protection settings handed to the array address decoder.
   typedef struct packed {
      logic       use_block_locks;
      logic       range_valid;
      logic       complement_protect;
      logic       protect_unit_small;
      logic       top_bottom_select;
      logic [2:0] protect_level;
   } fsp_prot_t;
   // Readable status bytes.
   typedef struct packed {
      logic [7:0] config_status_three;
      logic [7:0] status_two;
      logic [7:0] status_one;
   } fsp_stat_t;
   typedef enum logic [2:0] {
      FSP_IDLE    = 3'b001,
      FSP_ARRAY   = 3'b010,
      FSP_SRWRITE = 3'b100
   } fsp_state_t;
endpackage

// ===== logic/fsp_regs.sv
// Status, configuration and protection register logic of a serial flash.
//
// Function
// - Pin role: pause when 0, reset when 1
// - Scheme select picks range fields or locks
// - Busy flag set during program, erase, write
// - Busy ignores all but read status
// - Write enable sets the enable latch
// - Latch cleared on reset, disable, writes
// - Three-bit protect level, default none
// - Top/bottom bit selects counting direction
// - Unit bit selects blocks or sectors
// - Complement bit inverts selected protection
// - Lock mode 01 gates writes with pin, 00 never does
// - Lock mode 10 holds until reset
// - Lock mode 11 refuses writes forever if persistent, until reset if volatile only
// - Status write data never reaches busy, latch, suspend
// - Enabled write updates persistent copies
// - Volatile enable updates volatile copies only
// - Lock bits have no volatile copy
// - Suspend flag set by suspend, cleared by resume
// - Three one-time lock bits, never clear
// - Quad enable turns pins into data lines
// - Reset reloads volatile copies from persistent
`timescale 1ns/100ps
`include "fsp_cfg.svh"
module fsp_regs
(
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   input  wire logic              clk_en,
   input  wire logic              spi_clk,
   input  wire fsp_pkg::fsp_cmd_t cmd,
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   output fsp_pkg::fsp_stat_t     stat_link,
   input  wire logic              wp_n_pin,
   input  wire logic              pause_reset_n_pin,
   input  wire logic              op_done,
   output logic                   op_start,
   output logic [7:0]             op_code,
   output fsp_pkg::fsp_prot_t     prot,
   output logic [2:0]             sec_reg_read_only,
   output logic                   data_line_two_en,
   output logic                   data_line_three_en,
   output logic                   pause_active,
   output logic                   pin_reset_active,
   output logic [1:0]             drive_strength,
   output logic                   high_freq_mode
);
   import fsp_pkg::*;

   localparam fsp_cfg_t CFG_DEFAULT = '{
      pin_role_select: 1'b0, drive_strength: `FSP_DEF_DRV,
      high_freq_mode: `FSP_DEF_HFM, protect_scheme_select: 1'b0,
      complement_protect: 1'b0, quad_enable: 1'b0,
      lock_mode_bit1: 1'b0, lock_mode_bit0: 1'b0,
      protect_unit_small: 1'b0, top_bottom_select: 1'b0,
      protect_level: `FSP_DEF_BP};

   // Link side: command hold register, request toggle, acknowledge sync.
   logic       lrst_meta_reg, lrst_reg;
   fsp_cmd_t   cmd_hold_reg;
   logic       req_tgl_reg;
   logic       ack_meta_reg, ack_sync_reg;
   logic       snap_meta_reg, snap_sync_reg, snap_seen_reg;
   // System side state.
   logic       req_meta_reg, req_sync_reg, req_seen_reg;
   logic       ack_tgl_reg;
   logic       wp_meta_reg, wp_n_reg, pr_meta_reg, pr_n_reg;
   fsp_cfg_t   vol_reg, nv_reg;
   logic [2:0] lock_bits_reg;
   logic       busy_reg, wel_reg, vwel_reg, sus_reg;
   fsp_state_t state_reg;
   fsp_stat_t  snap_reg;
   logic       snap_tgl_reg, snap_ack_meta_reg, snap_ack_reg;
   logic       snap_ack_tgl_reg;
   logic       op_start_reg;
   logic [7:0] op_code_reg;

   logic       new_cmd, sr_write, sr_allowed, array_op, pin_reset;
   logic [1:0] lock_mode;
   fsp_cmd_t   k;
   fsp_stat_t  live;
   fsp_cfg_t   wr_cfg;
   logic [2:0] wr_lock;

   // Reset reaches the link domain through two flops of its own.
   always_ff @(posedge spi_clk)
   begin
      lrst_meta_reg <= nrst;
      lrst_reg      <= lrst_meta_reg;
   end

   // A new command is only taken once the previous one was acknowledged,
   // because the link clock is faster than the system clock.
   assign cmd_ready = (req_tgl_reg == ack_sync_reg);

   // Capture a command and announce it with a toggle.
   always_ff @(posedge spi_clk)
   begin
      if (!lrst_reg)
      begin
         cmd_hold_reg <= '0;
         req_tgl_reg  <= 1'b0;
      end
      else if (cmd_valid && cmd_ready)
      begin
         cmd_hold_reg <= cmd;
         req_tgl_reg  <= ~req_tgl_reg;
      end
   end

   // Acknowledge and status-snapshot toggles from the system side.
   always_ff @(posedge spi_clk)
   begin
      if (!lrst_reg)
      begin
         ack_meta_reg  <= 1'b0;
         ack_sync_reg  <= 1'b0;
         snap_meta_reg <= 1'b0;
         snap_sync_reg <= 1'b0;
         snap_seen_reg <= 1'b0;
         stat_link     <= '0;
      end
      else
      begin
         ack_meta_reg  <= ack_tgl_reg;
         ack_sync_reg  <= ack_meta_reg;
         snap_meta_reg <= snap_tgl_reg;
         snap_sync_reg <= snap_meta_reg;
         snap_seen_reg <= snap_sync_reg;
         if (snap_sync_reg != snap_seen_reg)
            stat_link <= snap_reg;
      end
   end

   // Pins and the request toggle pass two flops before any use.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         req_meta_reg      <= 1'b0;
         req_sync_reg      <= 1'b0;
         req_seen_reg      <= 1'b0;
         wp_meta_reg       <= 1'b1;
         wp_n_reg          <= 1'b1;
         pr_meta_reg       <= 1'b1;
         pr_n_reg          <= 1'b1;
         snap_ack_meta_reg <= 1'b0;
         snap_ack_reg      <= 1'b0;
      end
      else if (clk_en)
      begin
         req_meta_reg      <= req_tgl_reg;
         req_sync_reg      <= req_meta_reg;
         req_seen_reg      <= req_sync_reg;
         wp_meta_reg       <= wp_n_pin;
         wp_n_reg          <= wp_meta_reg;
         pr_meta_reg       <= pause_reset_n_pin;
         pr_n_reg          <= pr_meta_reg;
         snap_ack_meta_reg <= snap_seen_reg;
         snap_ack_reg      <= snap_ack_meta_reg;
      end
   end

   // Command decode; the held command is stable until acknowledged.
   always_comb
   begin
      k         = cmd_hold_reg;
      new_cmd   = clk_en && (req_sync_reg != req_seen_reg);
      lock_mode = {vol_reg.lock_mode_bit1, vol_reg.lock_mode_bit0};
      sr_write  = (k.code == `FSP_OP_WRSR1) || (k.code == `FSP_OP_WRSR2) ||
                  (k.code == `FSP_OP_WRSR3);
      array_op  = (k.code == `FSP_OP_PROG) || (k.code == `FSP_OP_SECT_ER) ||
                  (k.code == `FSP_OP_BLK_ER) || (k.code == `FSP_OP_CHIP_ER);
      // The pin only guards writes while quad mode leaves it a control pin.
      sr_allowed = (lock_mode == `FSP_LOCK_SOFT) ||
                   ((lock_mode == `FSP_LOCK_HW) &&
                    (wp_n_reg || vol_reg.quad_enable));
      pin_reset  = vol_reg.pin_role_select && !vol_reg.quad_enable &&
                   !pr_n_reg;
   end

   // New configuration built from the status bytes of a write.
   always_comb
   begin
      wr_cfg  = vol_reg;
      wr_lock = lock_bits_reg;
      case (k.code)
         `FSP_OP_WRSR1:
         begin
            wr_cfg.lock_mode_bit0     = k.data[`FSP_SR1_LOCK_MODE_BIT0];
            wr_cfg.protect_unit_small = k.data[`FSP_SR1_SEC];
            wr_cfg.top_bottom_select  = k.data[`FSP_SR1_TB];
            wr_cfg.protect_level      =
               k.data[`FSP_SR1_BP_LSB +: 3];
            if (k.nbytes > 2'h1)
            begin
               wr_cfg.lock_mode_bit1     = k.data[8 + `FSP_SR2_LOCK_MODE_BIT1];
               wr_cfg.quad_enable        = k.data[8 + `FSP_SR2_QE];
               wr_cfg.complement_protect = k.data[8 + `FSP_SR2_CMP];
               wr_lock = lock_bits_reg | k.data[8 + `FSP_SR2_LB_LSB +: 3];
            end
         end
         `FSP_OP_WRSR2:
         begin
            wr_cfg.lock_mode_bit1     = k.data[`FSP_SR2_LOCK_MODE_BIT1];
            wr_cfg.quad_enable        = k.data[`FSP_SR2_QE];
            wr_cfg.complement_protect = k.data[`FSP_SR2_CMP];
            // Lock bits only ever go from 0 to 1.
            wr_lock = lock_bits_reg | k.data[`FSP_SR2_LB_LSB +: 3];
         end
         `FSP_OP_WRSR3:
         begin
            wr_cfg.pin_role_select       = k.data[`FSP_SR3_PIN_ROLE_SELECT];
            wr_cfg.drive_strength        = k.data[`FSP_SR3_DRV_LSB +: 2];
            wr_cfg.high_freq_mode        = k.data[`FSP_SR3_HFM];
            wr_cfg.protect_scheme_select = k.data[`FSP_SR3_WPS];
         end
         default:
         begin
            wr_cfg  = vol_reg;
            wr_lock = lock_bits_reg;
         end
      endcase
   end

   // Acknowledge every taken command, accepted or ignored alike.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         ack_tgl_reg <= 1'b0;
      else if (new_cmd)
         ack_tgl_reg <= req_sync_reg;
   end

   // Embedded operation sequencing and the busy flag.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         state_reg    <= FSP_IDLE;
         busy_reg     <= 1'b0;
         op_start_reg <= 1'b0;
         op_code_reg  <= 8'h00;
      end
      else if (clk_en)
      begin
         op_start_reg <= 1'b0;
         case (state_reg)
            FSP_IDLE:
               if (pin_reset)
                  busy_reg <= 1'b0;
               else if (new_cmd && wel_reg && array_op)
               begin
                  state_reg    <= FSP_ARRAY;
                  busy_reg     <= 1'b1;
                  op_start_reg <= 1'b1;
                  op_code_reg  <= k.code;
               end
               else if (new_cmd && wel_reg && sr_write && sr_allowed)
               begin
                  state_reg    <= FSP_SRWRITE;
                  busy_reg     <= 1'b1;
                  op_start_reg <= 1'b1;
                  op_code_reg  <= k.code;
               end
            FSP_ARRAY, FSP_SRWRITE:
               // The reset pin aborts any running operation.
               if (op_done || pin_reset)
               begin
                  state_reg <= FSP_IDLE;
                  busy_reg  <= 1'b0;
               end
            default:
            begin
               state_reg <= FSP_IDLE;
               busy_reg  <= 1'b0;
            end
         endcase
      end
   end

   // Write enable latches; commands met while busy are ignored.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         wel_reg  <= 1'b0;
         vwel_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         if (pin_reset)
         begin
            wel_reg  <= 1'b0;
            vwel_reg <= 1'b0;
         end
         else if (new_cmd && !busy_reg)
         begin
            if (k.code == `FSP_OP_WREN)
               wel_reg <= 1'b1;
            else if ((k.code == `FSP_OP_WRDI) || array_op || sr_write ||
                     (k.code == `FSP_OP_SOFT_RST))
               wel_reg <= 1'b0;
            vwel_reg <= (k.code == `FSP_OP_VWREN);
         end
      end
   end

   // Suspend flag, kept apart from status writes.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         sus_reg <= 1'b0;
      else if (clk_en && new_cmd && !busy_reg)
      begin
         if (k.code == `FSP_OP_SUSPEND)
            sus_reg <= 1'b1;
         else if (k.code == `FSP_OP_RESUME)
            sus_reg <= 1'b0;
      end
   end

   // Persistent copies; a power-supply lock does not survive a reset.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         nv_reg        <= CFG_DEFAULT;
         lock_bits_reg <= `FSP_DEF_LB;
      end
      else if (clk_en)
      begin
         if (new_cmd && !busy_reg && (k.code == `FSP_OP_SOFT_RST) &&
             (lock_mode == `FSP_LOCK_POWER))
         begin
            nv_reg.lock_mode_bit1 <= 1'b0;
            nv_reg.lock_mode_bit0 <= 1'b0;
         end
         else if (new_cmd && !busy_reg && wel_reg && sr_write &&
                  sr_allowed)
         begin
            nv_reg        <= wr_cfg;
            lock_bits_reg <= wr_lock;
         end
      end
   end

   // Volatile copies steer the block; reset reloads them.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         vol_reg <= CFG_DEFAULT;
      else if (clk_en)
      begin
         if (pin_reset ||
             (new_cmd && !busy_reg && (k.code == `FSP_OP_SOFT_RST)))
         begin
            vol_reg <= nv_reg;
            if ({nv_reg.lock_mode_bit1, nv_reg.lock_mode_bit0} ==
                `FSP_LOCK_POWER)
            begin
               vol_reg.lock_mode_bit1 <= 1'b0;
               vol_reg.lock_mode_bit0 <= 1'b0;
            end
         end
         else if (new_cmd && !busy_reg && sr_write && sr_allowed &&
                  (wel_reg || vwel_reg))
            vol_reg <= wr_cfg;
      end
   end

   // Status bytes; reserved positions read as zero.
   always_comb
   begin
      live.status_one = {vol_reg.lock_mode_bit0, vol_reg.protect_unit_small,
                         vol_reg.top_bottom_select, vol_reg.protect_level,
                         wel_reg, busy_reg};
      live.status_two = {sus_reg, vol_reg.complement_protect,
                         lock_bits_reg, 1'b0, vol_reg.quad_enable,
                         vol_reg.lock_mode_bit1};
      live.config_status_three = {vol_reg.pin_role_select,
                                  vol_reg.drive_strength,
                                  vol_reg.high_freq_mode, 1'b0,
                                  vol_reg.protect_scheme_select, 2'b00};
   end

   // Snapshot handed across only when the link has taken the last one.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         snap_reg         <= '0;
         snap_tgl_reg     <= 1'b0;
         snap_ack_tgl_reg <= 1'b0;
      end
      else if (clk_en && (snap_ack_reg == snap_tgl_reg) &&
               (snap_reg != live))
      begin
         snap_reg     <= live;
         snap_tgl_reg <= ~snap_tgl_reg;
      end
   end

   // Outputs to the array decoder and the pad logic.
   always_comb
   begin
      prot.use_block_locks    = vol_reg.protect_scheme_select;
      prot.range_valid        = !vol_reg.protect_scheme_select;
      prot.complement_protect = vol_reg.complement_protect;
      prot.protect_unit_small = vol_reg.protect_unit_small;
      prot.top_bottom_select  = vol_reg.top_bottom_select;
      prot.protect_level      = vol_reg.protect_level;
   end
   assign sec_reg_read_only  = lock_bits_reg;
   assign data_line_two_en   = vol_reg.quad_enable;
   assign data_line_three_en = vol_reg.quad_enable;
   assign pause_active       = !vol_reg.pin_role_select &&
                               !vol_reg.quad_enable && !pr_n_reg;
   assign pin_reset_active   = pin_reset;
   assign drive_strength     = vol_reg.drive_strength;
   assign high_freq_mode     = vol_reg.high_freq_mode;
   assign op_start           = op_start_reg;
   assign op_code            = op_code_reg;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   AST_BUSY_ON_START: assert property (op_start |-> busy_reg)
      else $error("Busy not set with operation start.");
   AST_BUSY_CLEARS: assert property (
      (busy_reg && clk_en && op_done) |=> !busy_reg)
      else $error("Busy not cleared on completion.");
   AST_BUSY_IGNORES: assert property (
      (busy_reg && new_cmd && (k.code == `FSP_OP_WREN) && !wel_reg)
      |=> !wel_reg)
      else $error("Write enable taken while busy.");
   AST_WEL_SET: assert property (
      (new_cmd && !busy_reg && !pin_reset && (k.code == `FSP_OP_WREN))
      |=> wel_reg)
      else $error("Write enable latch not set.");
   AST_WEL_CLEAR: assert property (
      (new_cmd && !busy_reg && (array_op || sr_write)) |=> !wel_reg)
      else $error("Write enable latch not cleared.");
   AST_OTP_LOCK_HOLDS: assert property (
      (lock_mode == `FSP_LOCK_OTP) |=> ($stable(nv_reg) &&
      (lock_mode == `FSP_LOCK_OTP)))
      else $error("Permanent lock changed.");
   AST_HW_LOCK: assert property (
      ((lock_mode == `FSP_LOCK_HW) && !wp_n_reg && !vol_reg.quad_enable &&
       !pin_reset && new_cmd && sr_write && !busy_reg)
      |=> $stable(vol_reg))
      else $error("Write passed a low protect pin.");
   AST_POWER_LOCK: assert property (
      ((lock_mode == `FSP_LOCK_POWER) && new_cmd && sr_write)
      |=> $stable(nv_reg))
      else $error("Write passed the supply lock.");
   AST_LOCK_BITS_STICK: assert property (
      &(lock_bits_reg | ~$past(lock_bits_reg)))
      else $error("One-time lock bit cleared.");
   AST_SUS_SET: assert property (
      (new_cmd && !busy_reg && (k.code == `FSP_OP_SUSPEND)) |=> sus_reg)
      else $error("Suspend flag not set.");
   AST_VOL_KEEPS_NV: assert property (
      (new_cmd && !busy_reg && !wel_reg && sr_write) |=> $stable(nv_reg))
      else $error("Volatile write reached persistent bits.");
   AST_RANGE_OFF: assert property (
      prot.use_block_locks |-> !prot.range_valid)
      else $error("Both protection schemes active.");

   COV_ARRAY_OP: cover property (op_start ##[1:50] !busy_reg);
   COV_SR_WRITE: cover property (state_reg == FSP_SRWRITE);
   COV_SUSPEND: cover property (sus_reg);
   COV_PIN_RESET: cover property (pin_reset);

endmodule // fsp_regs

// ===== dv/fsp_host.sv
// Host-side command issuer that drives the link of the status block.
`timescale 1ns/100ps
module fsp_host
(
   input  wire logic          spi_clk,
   input  wire logic          cmd_ready,
   output fsp_pkg::fsp_cmd_t  cmd,
   output logic               cmd_valid
);
   import fsp_pkg::*;
   // An idle link shows a changing pattern, so stale data is never reused.
   initial
   begin
      cmd = '1;
      cmd_valid = 1'b0;
   end
   // One command at a time: hold it until taken, then wait for acknowledge.
   task automatic issue(input logic [7:0] code, input logic [7:0] dat);
      int k;
      k = 0;
      @(posedge spi_clk);
      cmd <= '{code, 2'h1, {8'h00, dat}};
      cmd_valid <= 1'b1;
      do
      begin
         @(posedge spi_clk);
         k++;
      end
      while (cmd_ready !== 1'b1 && k < 500);
      cmd_valid <= 1'b0;
      cmd <= ~cmd;
      do
      begin
         @(posedge spi_clk);
         k++;
      end
      while (cmd_ready !== 1'b1 && k < 1000);
   endtask
endmodule // fsp_host

// ===== dv/fsp_regs_tb.sv
// Self-checking bench of the status and protection register block.
`timescale 1ns/100ps
module fsp_regs_tb;
   import fsp_pkg::*;
   logic        sys_clk, spi_clk, nrst, op_done, op_start, cmd_ready;
   logic        wp_n_pin, pause_reset_n_pin, cmd_valid, high_freq_mode;
   logic        data_line_two_en, pause_active, pin_reset_active;
   logic [7:0]  op_code;
   fsp_cmd_t    cmd;
   fsp_stat_t   stat_link;
   fsp_prot_t   prot;
   int          err_count, comparisons, eng_cnt, i;
   // Rows: opcode, data byte, write-protect pin, expected status bytes.
   logic [43:0] rows [26] = '{
      44'h06_00_1_100002, 44'h04_00_1_100000, 44'h01_3C_1_100000,
      44'h50_00_1_100000, 44'h01_5C_1_10005C, 44'h06_00_1_10005E,
      44'h01_DC_1_1000DC, 44'h06_00_0_1000DE, 44'h01_00_0_1000DC,
      44'h06_00_1_1000DE, 44'h01_9C_1_10009C, 44'h06_00_1_10009E,
      44'h31_08_1_10089C, 44'h50_00_1_10089C, 44'h31_00_1_10089C,
      44'h75_00_1_10889C, 44'h7A_00_1_10089C, 44'h06_00_1_10089E,
      44'h11_84_1_84089C, 44'h06_00_1_84089E, 44'h01_1C_1_84081C,
      44'h06_00_1_84081E, 44'h31_09_1_84091C, 44'h06_00_1_84091E,
      44'h01_00_1_84091C, 44'h99_00_1_84081C};

   fsp_host host (.spi_clk, .cmd_ready, .cmd, .cmd_valid);
   fsp_regs dut (.sys_clk, .nrst, .clk_en(1'b1), .spi_clk, .cmd,
      .cmd_valid, .cmd_ready, .stat_link, .wp_n_pin, .pause_reset_n_pin,
      .op_done, .op_start, .op_code, .prot, .sec_reg_read_only(),
      .data_line_two_en, .data_line_three_en(), .pause_active,
      .pin_reset_active, .drive_strength(), .high_freq_mode);

   // The two clocks start apart so their edges never line up.
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial
   begin
      spi_clk = 1'b0;
      #3;
      forever #6 spi_clk = ~spi_clk;
   end
   // Array engine stand-in: ends each started operation 30 cycles later.
   always @(negedge sys_clk)
   begin
      op_done <= (eng_cnt == 1);
      eng_cnt <= op_start ? 30 : (eng_cnt > 0 ? eng_cnt - 1 : 0);
   end

   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // Waits a bounded time for the snapshot to settle, then compares.
   task automatic chk_stat(input logic [23:0] mask, input logic [23:0] exp);
      int k;
      logic [23:0] m;
      m = mask & 24'hF4FBFF;
      k = 0;
      while ((stat_link & m) !== exp && k < 300)
      begin
         @(posedge sys_clk);
         k++;
      end
      comparisons++;
      if ((stat_link & m) !== exp)
      begin
         err_count++;
         $display("Error at %0t: status %h not %h", $time, stat_link, exp);
      end
   endtask
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t: output %h not %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // A hang costs a mismatch; every test together takes well under this.
   initial
   begin
      #1_000_000;
      err_count++;
      stop_test;
   end

   initial
   begin
      nrst = 1'b0;
      wp_n_pin = 1'b1;
      pause_reset_n_pin = 1'b1;
      op_done = 1'b0;
      eng_cnt = 0;
      err_count = 0;
      comparisons = 0;
      tick(3);
      nrst = 1'b1;
      tick(2);
      chk_stat(24'hFFFFFF, 24'h100000);
      chk_val(8'(high_freq_mode), 8'h01);
      chk_val(8'(prot.protect_level), 8'h00);
      $display("reset test done");
      // A suspend sent during a program must be ignored.
      host.issue(8'h06, 8'h00);
      host.issue(8'h02, 8'h00);
      chk_stat(24'h000001, 24'h000001);
      chk_val(op_code, 8'h02);
      host.issue(8'h75, 8'h00);
      chk_stat(24'hFFFFFF, 24'h100000);
      $display("busy test done");
      for (i = 0; i < 26; i++)
      begin
         tick(1);
         wp_n_pin = rows[i][24];
         host.issue(rows[i][43:36], rows[i][35:28]);
         chk_stat(24'hFFFFFF, rows[i][23:0]);
      end
      $display("table test done");
      chk_val(8'(prot.use_block_locks), 8'h01);
      chk_val(8'(prot.protect_level), 8'h07);
      chk_val(8'(high_freq_mode), 8'h00);
      pause_reset_n_pin = 1'b0;
      tick(4);
      chk_val(8'(pin_reset_active), 8'h01);
      chk_val(8'(pause_active), 8'h00);
      pause_reset_n_pin = 1'b1;
      tick(4);
      host.issue(8'h06, 8'h00);
      host.issue(8'h31, 8'h0A);
      chk_stat(24'hFFFFFF, 24'h840A1C);
      chk_val(8'(data_line_two_en), 8'h01);
      pause_reset_n_pin = 1'b0;
      tick(4);
      chk_val(8'(pin_reset_active), 8'h00);
      pause_reset_n_pin = 1'b1;
      $display("pin role test done");
      stop_test;
   end
endmodule // fsp_regs_tb
